// [design/bfx_pkg.sv]
// Shared constants and types for the bidirectional FIFO pair and its host.
// Assumes both ends run on the single ref_clk domain.
package bfx_pkg;

  // Word and array geometry.
  localparam int DATA_W  = 36;
  localparam int DEPTH   = 1024;
  localparam int PTR_W   = 10;
  localparam int CNT_W   = 11;
  localparam int OFS_W   = 10;
  localparam int OFS_NUM = 4;

  localparam logic [CNT_W-1:0] CNT_ZERO  = 11'h000;
  localparam logic [CNT_W-1:0] CNT_DEPTH = 11'h400;
  localparam logic [CNT_W-1:0] CNT_ONE   = 11'h001;
  localparam logic [PTR_W-1:0] PTR_ZERO  = 10'h000;
  localparam logic [PTR_W-1:0] PTR_ONE   = 10'h001;

  // Default flag offsets, picked by the two offset-select pins at reset.
  localparam logic [OFS_W-1:0] OFS_8    = 10'h008;
  localparam logic [OFS_W-1:0] OFS_16   = 10'h010;
  localparam logic [OFS_W-1:0] OFS_64   = 10'h040;
  localparam logic [OFS_W-1:0] OFS_ZERO = 10'h000;
  localparam logic [1:0] FS_PARALLEL = 2'h0;
  localparam logic [1:0] FS_OFS8     = 2'h1;
  localparam logic [1:0] FS_OFS16    = 2'h2;

  // Offset register slots: slot 2*fifo + kind, kind 0 almost-empty, 1 almost-full.
  localparam int IDX_AE = 0;
  localparam int IDX_AF = 1;

  // Host port strobe divider: one strobe every two ref_clk cycles.
  localparam logic [1:0] DIV_LAST = 2'h1;
  localparam logic [1:0] DIV_ZERO = 2'h0;

  typedef enum logic [1:0] {
    HS_IDLE,
    HS_WAIT,
    HS_ISSUE,
    HS_CAPT
  } bfx_hstate_t;

endpackage : bfx_pkg

// [design/bfx_link_if.sv]
// Pin-level link between the FIFO device end and the host end.
// Assumes both ends share ref_clk; side clocks are one-cycle strobes.
`timescale 1ns/1ps
`default_nettype none
interface bfx_link_if;
  import bfx_pkg::*;
  // Port side A and side B pins.
  logic              sideAClock;
  logic              sideBClock;
  logic              sideAPortSelect_n;
  logic              sideBPortSelect_n;
  logic              sideAEnable;
  logic              sideBEnable;
  logic              sideAWrite;
  logic              sideBWrite;
  logic              sideAMailbox;
  logic              sideBMailbox;
  logic [DATA_W-1:0] sideAHostData;
  logic [DATA_W-1:0] sideBHostData;
  logic              sideAHostOe_n;
  logic              sideBHostOe_n;
  logic [DATA_W-1:0] sideADevData;
  logic [DATA_W-1:0] sideBDevData;
  logic              sideADevOe_n;
  logic              sideBDevOe_n;
  // Status flags.
  logic              sideAEmptyOrOutReady;
  logic              sideBEmptyOrOutReady;
  logic              sideAFullOrInReady;
  logic              sideBFullOrInReady;
  logic              sideAAlmostEmpty_n;
  logic              sideBAlmostEmpty_n;
  logic              sideAAlmostFull_n;
  logic              sideBAlmostFull_n;
  logic              mailboxOneFullFlag;
  logic              mailboxTwoFullFlag;
  // Reset-time configuration.
  logic              firstFifoMasterReset_n;
  logic              secondFifoMasterReset_n;
  logic              offsetSelectLow;
  logic              offsetSelectHigh;
  logic              timingModeSelect;

  modport dev (
    input  sideAClock, sideBClock, sideAPortSelect_n, sideBPortSelect_n,
    input  sideAEnable, sideBEnable, sideAWrite, sideBWrite, sideAMailbox, sideBMailbox,
    input  sideAHostData, sideBHostData, sideAHostOe_n, sideBHostOe_n,
    input  firstFifoMasterReset_n, secondFifoMasterReset_n,
    input  offsetSelectLow, offsetSelectHigh, timingModeSelect,
    output sideADevData, sideBDevData, sideADevOe_n, sideBDevOe_n,
    output sideAEmptyOrOutReady, sideBEmptyOrOutReady, sideAFullOrInReady,
    output sideBFullOrInReady, sideAAlmostEmpty_n, sideBAlmostEmpty_n,
    output sideAAlmostFull_n, sideBAlmostFull_n, mailboxOneFullFlag, mailboxTwoFullFlag
  );

  modport host (
    output sideAClock, sideBClock, sideAPortSelect_n, sideBPortSelect_n,
    output sideAEnable, sideBEnable, sideAWrite, sideBWrite, sideAMailbox, sideBMailbox,
    output sideAHostData, sideBHostData, sideAHostOe_n, sideBHostOe_n,
    output firstFifoMasterReset_n, secondFifoMasterReset_n,
    output offsetSelectLow, offsetSelectHigh, timingModeSelect,
    input  sideADevData, sideBDevData, sideADevOe_n, sideBDevOe_n,
    input  sideAEmptyOrOutReady, sideBEmptyOrOutReady, sideAFullOrInReady,
    input  sideBFullOrInReady, sideAAlmostEmpty_n, sideBAlmostEmpty_n,
    input  sideAAlmostFull_n, sideBAlmostFull_n, mailboxOneFullFlag, mailboxTwoFullFlag
  );
endinterface : bfx_link_if
`default_nettype wire

// [design/bfx_fifo_device.sv]
// Device end: two 36-bit FIFOs in opposite directions, two mailboxes, flags.
// Assumes port strobes and controls come from logic on ref_clk (no sync needed).
// Function
// - Two 36-bit FIFOs, opposite directions.
// - Transfers only on enabled port strobe.
// - Both ports may act in one cycle.
// - Two mailboxes bypass FIFOs, port-B width.
// - Each mailbox flags newly stored word.
// - Master reset zeroes both pointers.
// - Separate master reset per FIFO.
// - Offset selects pick parallel or 8/16/64.
// - Default offset from empty/full boundary.
// - Parallel offsets written through port A.
// - Standard mode: first word needs read.
// - Fall-through: first word appears unread.
// - Mode input picks standard or fall-through.
// - Combined flags: empty/full or ready.
// - Ready flags mean space, valid output.
// - Flags timed to their own port.
// - Almost flags may lag three cycles.
// - Fall-through reader gates on output-ready.
// - Mode sampled in reset, high standard.
// - Port select low enables, else undriven.
// - Almost-empty low when words <= offset.
// - Almost-full low when free <= offset.
`timescale 1ns/1ps
`default_nettype none
module bfx_fifo_core
  import bfx_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              clear,
  input  wire logic              fallThrough,
  input  wire logic              wrEn,
  input  wire logic              rdEn,
  input  wire logic              holdPreload,
  input  wire logic [DATA_W-1:0] dataIn,
  output logic      [DATA_W-1:0] headWord,
  output logic                   headLoad,
  output logic                   isFull,
  output logic                   hasData,
  output logic      [CNT_W-1:0]  level,
  output logic      [CNT_W-1:0]  freeSlots
);
  logic [DATA_W-1:0] mem [DEPTH];
  logic [PTR_W-1:0]  wrPtr_reg;
  logic [PTR_W-1:0]  rdPtr_reg;
  logic [CNT_W-1:0]  memCount_reg, memCount_next;
  logic              outValid_reg, outValid_next;
  logic              wrOk, memNotEmpty, fwftPull;

  assign wrOk        = wrEn & ~isFull;
  assign memNotEmpty = memCount_reg != CNT_ZERO;
  assign isFull      = memCount_reg == CNT_DEPTH;
  // In fall-through the output stage refills itself whenever it is empty or being read, except in a mailbox-read cycle.
  assign fwftPull    = memNotEmpty & (~outValid_reg | rdEn) & ~holdPreload;
  assign headLoad    = fallThrough ? fwftPull : (rdEn & memNotEmpty);
  assign headWord    = mem[rdPtr_reg];
  assign memCount_next = memCount_reg + (wrOk ? CNT_ONE : CNT_ZERO)
                       - (headLoad ? CNT_ONE : CNT_ZERO);
  assign outValid_next = fallThrough & (fwftPull | (outValid_reg & ~rdEn));
  assign hasData     = fallThrough ? outValid_reg : memNotEmpty;
  assign level       = memCount_reg + (outValid_reg ? CNT_ONE : CNT_ZERO);
  assign freeSlots   = CNT_DEPTH - memCount_reg;

  // Storage has no reset; the pointers and memCount_reg define what is valid.
  always_ff @(posedge ref_clk) begin
    if (wrOk) begin
      mem[wrPtr_reg] <= dataIn;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clear) begin
      wrPtr_reg    <= PTR_ZERO;
      rdPtr_reg    <= PTR_ZERO;
      memCount_reg <= CNT_ZERO;
      outValid_reg <= 1'b0;
    end else begin
      wrPtr_reg    <= wrOk ? wrPtr_reg + PTR_ONE : wrPtr_reg;
      rdPtr_reg    <= headLoad ? rdPtr_reg + PTR_ONE : rdPtr_reg;
      memCount_reg <= memCount_next;
      outValid_reg <= outValid_next;
    end
  end
endmodule : bfx_fifo_core

module bfx_fifo_device
  import bfx_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst_n,
  bfx_link_if.dev   link
);
  // Port index 0 is side A, 1 is side B; FIFO and mailbox k are written by port k.
  logic [1:0]        strobe, selN, ena, wrDir, mbxSel, mrstN;
  logic [DATA_W-1:0] hostData [2];
  logic [1:0]        wrReq, rdReq, fifoClr, fifoWr, fifoRd, mbxWr, mbxRd;
  logic [1:0]        fall_through_mode_reg;
  logic [DATA_W-1:0] headWord [2];
  logic [1:0]        headLoad, isFull, hasData;
  logic [CNT_W-1:0]  level [2], freeSlots [2];
  logic [DATA_W-1:0] mbox_reg [2], dout_reg [2];
  logic [1:0]        mbxFull_reg;
  logic [1:0]        oeN_reg, emptyOr_reg, fullOr_reg, aeN_reg, afN_reg;
  logic [OFS_W-1:0]  ofs_reg [OFS_NUM];
  logic [OFS_NUM-1:0] pending_reg;
  logic [1:0]        fsSel;
  logic [OFS_W-1:0]  defaultOfs;
  logic              ofsLoad;
  logic [1:0]        loadIdx;

  function automatic logic [1:0] lowestSet(input logic [OFS_NUM-1:0] bits);
    lowestSet = 2'h0;
    for (int i = OFS_NUM - 1; i >= 0; i--) begin
      if (bits[i]) begin
        lowestSet = 2'(i);
      end
    end
  endfunction : lowestSet

  // Gather the scalar pins into per-port vectors.
  assign strobe   = {link.sideBClock, link.sideAClock};
  assign selN     = {link.sideBPortSelect_n, link.sideAPortSelect_n};
  assign ena      = {link.sideBEnable, link.sideAEnable};
  assign wrDir    = {link.sideBWrite, link.sideAWrite};
  assign mbxSel   = {link.sideBMailbox, link.sideAMailbox};
  assign mrstN    = {link.secondFifoMasterReset_n, link.firstFifoMasterReset_n};
  assign hostData[0] = link.sideAHostData;
  assign hostData[1] = link.sideBHostData;
  assign fsSel    = {link.offsetSelectHigh, link.offsetSelectLow};

  assign defaultOfs = (fsSel == FS_OFS8)  ? OFS_8 :
                      (fsSel == FS_OFS16) ? OFS_16 : OFS_64;
  assign ofsLoad  = wrReq[0] & ~mbxSel[0] & (|pending_reg);
  assign loadIdx  = lowestSet(pending_reg);

  // Offset slots load in order: FIFO1 empty, FIFO1 full, FIFO2 empty, FIFO2 full.
  for (genvar i = 0; i < OFS_NUM; i++) begin : g_ofs
    always_ff @(posedge ref_clk) begin
      if (fifoClr[i / 2]) begin
        ofs_reg[i]     <= (fsSel == FS_PARALLEL) ? OFS_ZERO : defaultOfs;
        pending_reg[i] <= fsSel == FS_PARALLEL;
      end else if (ofsLoad && loadIdx == 2'(i)) begin
        ofs_reg[i]     <= hostData[0][OFS_W-1:0];
        pending_reg[i] <= 1'b0;
      end
    end
  end

  for (genvar p = 0; p < 2; p++) begin : g_port
    localparam int R = 1 - p;

    assign wrReq[p]  = strobe[p] & ~selN[p] & ena[p] & wrDir[p];
    assign rdReq[p]  = strobe[p] & ~selN[p] & ena[p] & ~wrDir[p];
    assign fifoClr[p] = ~rst_n | ~mrstN[p];
    // A feeds B, B feeds A
    assign fifoWr[p] = wrReq[p] & ~mbxSel[p] & ~((p == 0) ? ofsLoad : 1'b0);
    assign fifoRd[p] = rdReq[R] & ~mbxSel[R];
    assign mbxWr[p]  = wrReq[p] & mbxSel[p];
    assign mbxRd[p]  = rdReq[R] & mbxSel[R];

    always_ff @(posedge ref_clk) begin
      if (fifoClr[p]) begin
        fall_through_mode_reg[p] <= ~link.timingModeSelect;
      end
    end

    bfx_fifo_core u_core (
      .ref_clk     (ref_clk),
      .clear       (fifoClr[p]),
      .fallThrough (fall_through_mode_reg[p]),
      .wrEn        (fifoWr[p]),
      .rdEn        (fifoRd[p]),
      .holdPreload (mbxRd[p]),
      .dataIn      (hostData[p]),
      .headWord    (headWord[p]),
      .headLoad    (headLoad[p]),
      .isFull      (isFull[p]),
      .hasData     (hasData[p]),
      .level       (level[p]),
      .freeSlots   (freeSlots[p])
    );

    // new-mail flag
    // A new mail arriving in the cycle the old one is read still sets the flag.
    always_ff @(posedge ref_clk) begin
      if (fifoClr[p]) begin
        mbxFull_reg[p] <= 1'b0;
        mbox_reg[p]    <= '0;
      end else begin
        mbxFull_reg[p] <= (mbxWr[p] & ~mbxFull_reg[p]) | (mbxFull_reg[p] & ~mbxRd[p])
                        | (mbxWr[p] & mbxRd[p]);
        if (mbxWr[p] && (!mbxFull_reg[p] || mbxRd[p])) begin
          mbox_reg[p] <= hostData[p];
        end
      end
    end

    // Read data of port p comes from FIFO R or mailbox R; they never load together.
    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        dout_reg[p] <= '0;
        oeN_reg[p]  <= 1'b1;
      end else begin
        oeN_reg[p]  <= selN[p] | wrDir[p];
        if (headLoad[R]) begin
          dout_reg[p] <= headWord[R];
        end else if (mbxRd[R]) begin
          dout_reg[p] <= mbox_reg[R];
        end
      end
    end

    always_ff @(posedge ref_clk) begin
      if (fifoClr[p]) begin
        fullOr_reg[p] <= 1'b0;
        afN_reg[p]    <= 1'b1;
      end else begin
        fullOr_reg[p] <= ~isFull[p];
        afN_reg[p]    <= freeSlots[p] > {1'b0, ofs_reg[2 * p + IDX_AF]};
      end
      if (fifoClr[R]) begin
        emptyOr_reg[p] <= 1'b0;
        aeN_reg[p]     <= 1'b0;
      end else begin
        emptyOr_reg[p] <= hasData[R];
        aeN_reg[p]     <= level[R] > {1'b0, ofs_reg[2 * R + IDX_AE]};
      end
    end
  end

  // Drive the pins straight from their flops.
  assign link.sideADevData         = dout_reg[0];
  assign link.sideBDevData         = dout_reg[1];
  assign link.sideADevOe_n         = oeN_reg[0];
  assign link.sideBDevOe_n         = oeN_reg[1];
  assign link.sideAEmptyOrOutReady = emptyOr_reg[0];
  assign link.sideBEmptyOrOutReady = emptyOr_reg[1];
  assign link.sideAFullOrInReady   = fullOr_reg[0];
  assign link.sideBFullOrInReady   = fullOr_reg[1];
  assign link.sideAAlmostEmpty_n   = aeN_reg[0];
  assign link.sideBAlmostEmpty_n   = aeN_reg[1];
  assign link.sideAAlmostFull_n    = afN_reg[0];
  assign link.sideBAlmostFull_n    = afN_reg[1];
  assign link.mailboxOneFullFlag   = mbxFull_reg[0];
  assign link.mailboxTwoFullFlag   = mbxFull_reg[1];
endmodule : bfx_fifo_device
`default_nettype wire

// [design/bfx_fifo_host.sv]
// Host end: turns user requests per port into strobed pin cycles.
// Assumes the device end shares ref_clk; flags are read without synchronisers.
`timescale 1ns/1ps
`default_nettype none
module bfx_fifo_host
  import bfx_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  input  wire logic [1:0]             reqValid,
  input  wire logic [1:0]             reqWrite,
  input  wire logic [1:0]             reqMailbox,
  input  wire logic [1:0][DATA_W-1:0] reqData,
  output logic      [1:0]             reqReady,
  output logic      [1:0]             rspValid,
  output logic      [1:0][DATA_W-1:0] rspData,
  input  wire logic [1:0]             cfgReset_n,
  input  wire logic [1:0]             cfgOffsetSel,
  input  wire logic                   cfgStandard,
  bfx_link_if.host                    link
);
  logic [1:0]             strobe_reg;
  logic [1:0]             selN_reg;
  logic [1:0]             ena_reg;
  logic [1:0]             wr_reg;
  logic [1:0]             mbx_reg;
  logic [1:0]             oeN_reg;
  logic [1:0][DATA_W-1:0] data_reg;
  logic [1:0]             mrstN_reg;
  logic [1:0]             fs_reg;
  logic                   mode_reg;
  logic [1:0]             outReady;
  logic [1:0]             inReady;
  logic [1:0]             mbxFull;
  logic [1:0][DATA_W-1:0] devData;

  assign outReady = {link.sideBEmptyOrOutReady, link.sideAEmptyOrOutReady};
  assign inReady  = {link.sideBFullOrInReady, link.sideAFullOrInReady};
  assign mbxFull  = {link.mailboxTwoFullFlag, link.mailboxOneFullFlag};
  assign devData  = {link.sideBDevData, link.sideADevData};

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      // The device samples these while the master resets are held, so follow the inputs here.
      mrstN_reg <= 2'h0;
      fs_reg    <= cfgOffsetSel;
      mode_reg  <= cfgStandard;
    end else begin
      mrstN_reg <= cfgReset_n;
      if (cfgReset_n != 2'h3) begin
        fs_reg   <= cfgOffsetSel;
        mode_reg <= cfgStandard;
      end
    end
  end

  for (genvar p = 0; p < 2; p++) begin : g_port
    localparam int R = 1 - p;
    bfx_hstate_t state_reg;
    logic [1:0]  div_reg;
    logic        tick;
    logic        gateOk;
    logic        lateCapt;

    assign tick = div_reg == DIV_LAST;
    // flags settle before reuse
    // Fall-through shows the head word before the read, which then loads the next word.
    assign lateCapt = mode_reg | mbx_reg[p];
    assign gateOk = mbx_reg[p] ?
                    (wr_reg[p] ? ~mbxFull[p] : mbxFull[R]) :
                    (wr_reg[p] ? inReady[p] : outReady[p]);

    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        div_reg       <= DIV_ZERO;
        strobe_reg[p] <= 1'b0;
      end else begin
        div_reg       <= tick ? DIV_ZERO : div_reg + 2'h1;
        strobe_reg[p] <= tick;
      end
    end

    // Pins are set on the same edge that raises the strobe, so they are stable through the strobe cycle.
    always_ff @(posedge ref_clk) begin
      if (!rst_n || !mrstN_reg[p]) begin
        state_reg   <= HS_IDLE;
        selN_reg[p] <= 1'b1;
        ena_reg[p]  <= 1'b0;
        wr_reg[p]   <= 1'b0;
        mbx_reg[p]  <= 1'b0;
        oeN_reg[p]  <= 1'b1;
        data_reg[p] <= '0;
        reqReady[p] <= 1'b0;
        rspValid[p] <= 1'b0;
        rspData[p]  <= '0;
      end else begin
        rspValid[p] <= 1'b0;
        unique case (state_reg)
          HS_IDLE: begin
            reqReady[p] <= ~reqValid[p];
            if (reqValid[p] && reqReady[p]) begin
              wr_reg[p]   <= reqWrite[p];
              mbx_reg[p]  <= reqMailbox[p];
              data_reg[p] <= reqData[p];
              state_reg   <= HS_WAIT;
            end
          end
          HS_WAIT: begin
            if (tick && gateOk) begin
              selN_reg[p] <= 1'b0;
              ena_reg[p]  <= 1'b1;
              oeN_reg[p]  <= ~wr_reg[p];
              state_reg   <= HS_ISSUE;
            end
          end
          HS_ISSUE: begin
            ena_reg[p] <= 1'b0;
            oeN_reg[p] <= 1'b1;
            if (wr_reg[p]) begin
              selN_reg[p] <= 1'b1;
              reqReady[p] <= 1'b1;
              state_reg   <= HS_IDLE;
            end else begin
              rspData[p] <= lateCapt ? rspData[p] : devData[p];
              state_reg  <= HS_CAPT;
            end
          end
          HS_CAPT: begin
            selN_reg[p] <= 1'b1;
            rspValid[p] <= 1'b1;
            rspData[p]  <= lateCapt ? devData[p] : rspData[p];
            reqReady[p] <= 1'b1;
            state_reg   <= HS_IDLE;
          end
        endcase
      end
    end
  end

  // Pin outputs straight from flops.
  assign link.sideAClock              = strobe_reg[0];
  assign link.sideBClock              = strobe_reg[1];
  assign link.sideAPortSelect_n       = selN_reg[0];
  assign link.sideBPortSelect_n       = selN_reg[1];
  assign link.sideAEnable             = ena_reg[0];
  assign link.sideBEnable             = ena_reg[1];
  assign link.sideAWrite              = wr_reg[0];
  assign link.sideBWrite              = wr_reg[1];
  assign link.sideAMailbox            = mbx_reg[0];
  assign link.sideBMailbox            = mbx_reg[1];
  assign link.sideAHostData           = data_reg[0];
  assign link.sideBHostData           = data_reg[1];
  assign link.sideAHostOe_n           = oeN_reg[0];
  assign link.sideBHostOe_n           = oeN_reg[1];
  assign link.firstFifoMasterReset_n  = mrstN_reg[0];
  assign link.secondFifoMasterReset_n = mrstN_reg[1];
  assign link.offsetSelectLow         = fs_reg[0];
  assign link.offsetSelectHigh        = fs_reg[1];
  assign link.timingModeSelect        = mode_reg;
endmodule : bfx_fifo_host
`default_nettype wire

// [dv/bfx_link_assertions.sv]
// Checker for the link between the FIFO device end and the host end.
// Assumes every link signal is sampled on ref_clk; the bench instantiates it.
`timescale 1ns/1ps
`default_nettype none
module bfx_link_assertions (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic sideAClock,
  input wire logic sideAPortSelect_n,
  input wire logic sideBPortSelect_n,
  input wire logic sideAWrite,
  input wire logic sideAMailbox,
  input wire logic sideADevOe_n,
  input wire logic sideBDevOe_n,
  input wire logic sideAFullOrInReady,
  input wire logic sideBEmptyOrOutReady,
  input wire logic sideBAlmostEmpty_n,
  input wire logic sideAAlmostFull_n,
  input wire logic mailboxOneFullFlag,
  input wire logic firstFifoMasterReset_n,
  input wire logic secondFifoMasterReset_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // A taken mailbox write at side A, and a link with no port selected and no reset.
  wire logic aMbxWr = sideAClock && !sideAPortSelect_n && sideAWrite && sideAMailbox;
  wire logic quiet  = sideAPortSelect_n && sideBPortSelect_n && firstFifoMasterReset_n
                      && secondFifoMasterReset_n;
  wire logic first_fifo_master_reset   = !firstFifoMasterReset_n;

  // Flags are registered, so every check allows the documented lag.
  side_a_hiz_a: assert property (sideAPortSelect_n [*2] |-> sideADevOe_n)
    else $error("Side A drives data while deselected.");
  side_b_hiz_a: assert property (sideBPortSelect_n [*2] |-> sideBDevOe_n)
    else $error("Side B drives data while deselected.");
  mail_set_cause_a: assert property ($rose(mailboxOneFullFlag) |->
    $past(aMbxWr) || $past(aMbxWr, 2) || $past(aMbxWr, 3))
    else $error("Mailbox flag rose without a mailbox write.");
  reset_not_ready_a: assert property (first_fifo_master_reset [*3] |-> !sideAFullOrInReady)
    else $error("Input flag high during master reset.");
  reset_empties_a: assert property (first_fifo_master_reset [*3] |-> !sideBEmptyOrOutReady)
    else $error("Output flag high during master reset.");
  reset_almost_empty_a: assert property (first_fifo_master_reset [*3] |-> !sideBAlmostEmpty_n)
    else $error("Almost-empty flag high with no words.");
  reset_not_full_a: assert property (first_fifo_master_reset [*3] |-> sideAAlmostFull_n)
    else $error("Almost-full flag low with all locations free.");
  idle_flags_a: assert property (quiet [*6] |->
    $stable({sideAFullOrInReady, sideBEmptyOrOutReady, mailboxOneFullFlag}))
    else $error("Flags moved without any port transfer.");

  cover property (aMbxWr);
  cover property ($rose(sideBEmptyOrOutReady));
  cover property (first_fifo_master_reset [*3]);
endmodule : bfx_link_assertions
`default_nettype wire

// [dv/bidir_dual_clock_fifo_tb.sv]
// Self-checking bench: host end and device end joined over the link interface.
// Assumes one 50 MHz clock; inputs change 1 ns after each rising edge.
`timescale 1ns/1ps
`default_nettype none
module bidir_dual_clock_fifo_tb;
  import bfx_pkg::*;
  logic                   ref_clk = 1'b0;
  logic                   rst_n = 1'b0;
  logic [1:0]             reqValid = 2'h0, reqWrite = 2'h0, reqMailbox = 2'h0;
  logic [1:0][DATA_W-1:0] reqData = '0, rspData;
  logic [1:0]             reqReady, rspValid, cfgReset_n = 2'h3, cfgOffsetSel = 2'h1;
  logic                   cfgStandard = 1'b1;
  int                     seed = 49, error_cnt = 0, n_compared = 0, cycles = 0;
  logic [DATA_W-1:0]      mdl[4][$], expQ[2][$];

  bfx_link_if link ();
  bfx_fifo_device bfx_fifo_device_i (.ref_clk(ref_clk), .rst_n(rst_n), .link(link.dev));
  bfx_fifo_host bfx_fifo_host_i (.ref_clk(ref_clk), .rst_n(rst_n), .reqValid(reqValid),
    .reqWrite(reqWrite), .reqMailbox(reqMailbox), .reqData(reqData), .reqReady(reqReady),
    .rspValid(rspValid), .rspData(rspData), .cfgReset_n(cfgReset_n),
    .cfgOffsetSel(cfgOffsetSel), .cfgStandard(cfgStandard), .link(link.host));
  bfx_link_assertions chk_i (.ref_clk(ref_clk), .rst_n(rst_n), .sideAClock(link.sideAClock),
    .sideAPortSelect_n(link.sideAPortSelect_n), .sideBPortSelect_n(link.sideBPortSelect_n),
    .sideAWrite(link.sideAWrite), .sideAMailbox(link.sideAMailbox),
    .sideADevOe_n(link.sideADevOe_n), .sideBDevOe_n(link.sideBDevOe_n),
    .sideAFullOrInReady(link.sideAFullOrInReady),
    .sideBEmptyOrOutReady(link.sideBEmptyOrOutReady),
    .sideBAlmostEmpty_n(link.sideBAlmostEmpty_n), .sideAAlmostFull_n(link.sideAAlmostFull_n),
    .mailboxOneFullFlag(link.mailboxOneFullFlag),
    .firstFifoMasterReset_n(link.firstFifoMasterReset_n),
    .secondFifoMasterReset_n(link.secondFifoMasterReset_n));

  always #10 ref_clk = ~ref_clk;

  function automatic logic [DATA_W-1:0] rnd();
    return DATA_W'({$random(seed), $random(seed)});
  endfunction : rnd

  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One request per call; valid rises only while ready is up, since a waiting valid keeps
  // ready low, and falls after the edge that takes it.
  task automatic op(input int p, input logic wr, input logic mb, input logic [DATA_W-1:0] d);
    @(posedge ref_clk) #1;
    while (reqReady[p] !== 1'b1) @(posedge ref_clk) #1;
    reqWrite[p] = wr;
    reqMailbox[p] = mb;
    reqData[p] = d;
    reqValid[p] = 1'b1;
    if (wr) mdl[{mb, ~p[0]}].push_back(d);
    else expQ[p].push_back(mdl[{mb, p[0]}].pop_front());
    @(posedge ref_clk) #1;
    reqValid[p] = 1'b0;
  endtask : op

  task automatic burst(input int p, input logic wr, input int n);
    for (int i = 0; i < n; i++) op(p, wr, 1'b0, rnd());
  endtask : burst

  task automatic test_done();
    if (expQ[0].size() + expQ[1].size() != 0) error_cnt++;
    $display("Compared %0d, mismatched %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done

  // Responses are taken at the falling edge, where the pulse has settled.
  always @(negedge ref_clk) begin
    cycles++;
    if (cycles > 5000) begin
      error_cnt++;
      test_done();
    end
    for (int p = 0; p < 2; p++)
      if (rspValid[p] === 1'b1)
        chk(rspData[p], expQ[p].size() != 0 ? expQ[p].pop_front() : ~rspData[p]);
  end

  // Main sequence: traffic both ways, flag boundary, mailboxes, resets, fall-through.
  initial begin
    repeat (4) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    fork burst(0, 1'b1, 10); burst(1, 1'b1, 10); join
    #200 chk(DATA_W'(link.sideBAlmostEmpty_n), DATA_W'(1));
    burst(1, 1'b0, 2);
    #200 chk(DATA_W'(link.sideBAlmostEmpty_n), '0);
    fork burst(1, 1'b0, 8); burst(0, 1'b0, 10); join
    fork op(0, 1'b1, 1'b1, rnd()); op(1, 1'b1, 1'b1, rnd()); join
    fork op(1, 1'b0, 1'b1, '0); op(0, 1'b0, 1'b1, '0); join
    burst(1, 1'b1, 3);
    burst(0, 1'b1, 2);
    #100 cfgReset_n = 2'h2;
    cfgOffsetSel = 2'h2;
    #80 cfgReset_n = 2'h3;
    mdl[1].delete();
    burst(0, 1'b0, 3);
    burst(0, 1'b1, 12);
    #200 chk(DATA_W'(link.sideBAlmostEmpty_n), '0);
    burst(1, 1'b0, 12);
    #200 cfgStandard = 1'b0;
    cfgOffsetSel = 2'h0;
    cfgReset_n = 2'h0;
    #80 cfgReset_n = 2'h3;
    repeat (4) op(0, 1'b1, 1'b0, 36'h2);
    mdl[1].delete();
    op(0, 1'b1, 1'b0, rnd());
    #200 chk(link.sideBDevData, mdl[1][0]);
    chk(DATA_W'(link.sideBEmptyOrOutReady), DATA_W'(1));
    chk(DATA_W'(link.sideBAlmostEmpty_n), '0);
    test_done();
  end
endmodule : bidir_dual_clock_fifo_tb
`default_nettype wire
